// [ltc_regs.svh]
// Overview of operation
// RL1: 16-bit read/write third LED start count in bits 15-0; zero when LED unused.
// RL2: 16-bit read/write third LED end count in bits 15-0; zero when LED unused.
// RL3: 3-bit divider field bits 2-0; codes 0,4,5,6,7 give ratios 1,2,4,8,16.
// RL4: timing clock equals conversion clock divided by selected ratio.
// RL5: software keeps repetition rate above divider minimum and never below 10 Hz.
// RL6: software writes zero to reserved bits 23-16 and 23-3.
// RL7: registers at 36h, 37h, 39h, 3Ah; all clear to zero on reset.
// RL8: offset DAC register holds polarity and 4-bit current code per phase.
// RL9: third LED driven while timing counter lies between start and end counts.
`ifndef LTC_REGS_SVH
`define LTC_REGS_SVH

// register addresses
`define LTC_ADDR_LED3_START   8'h36
`define LTC_ADDR_LED3_END     8'h37
`define LTC_ADDR_CLK_DIV      8'h39
`define LTC_ADDR_OFFSET_DAC   8'h3a

// field layout
`define LTC_COUNT_MSB         15
`define LTC_DIV_MSB           2
`define LTC_DAC_MSB           19
`define LTC_RESET_VALUE       24'h00_0000
`define LTC_READ_ZERO         24'h00_0000

// divider codes
`define LTC_DIV_CODE_BY2      3'h4
`define LTC_DIV_CODE_BY4      3'h5
`define LTC_DIV_CODE_BY8      3'h6
`define LTC_DIV_CODE_BY16     3'h7
`define LTC_RATIO_1           5'h01
`define LTC_RATIO_2           5'h02
`define LTC_RATIO_4           5'h04
`define LTC_RATIO_8           5'h08
`define LTC_RATIO_16          5'h10

// clock rates
`define LTC_CORE_CLK_KHZ      125000
`define LTC_CONV_CLK_KHZ      4000

// serial port framing
`define LTC_BITS_PER_BYTE     3'h7
`define LTC_LAST_BYTE         2'h2

`endif

// [ltc_pkg.sv]
package ltc_pkg;

   typedef struct packed {
      logic       pol_phase_b;
      logic [3:0] cur_phase_b;
      logic       pol_dark_a;
      logic [3:0] cur_dark_a;
      logic       pol_phase_a;
      logic [3:0] cur_phase_a;
      logic       pol_dark_b;
      logic [3:0] cur_dark_b;
   } ltc_offset_dac_s;

   typedef struct packed {
      logic [15:0] third_led_start_count;
      logic [15:0] third_led_end_count;
      logic [2:0]  timing_clock_div_sel;
   } ltc_timing_cfg_s;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEV_ADDR,
      ST_ACK_ADDR,
      ST_REG_ADDR,
      ST_ACK_REG,
      ST_WDATA,
      ST_ACK_WDATA,
      ST_RDATA,
      ST_RACK
   } ltc_port_state_e;

endpackage

// [ltc_timing.sv]
`timescale 1ns/100ps
`include "ltc_regs.svh"

module ltc_timing #(
   parameter int CONV_TICK_CYCLES = `LTC_CORE_CLK_KHZ / `LTC_CONV_CLK_KHZ
) (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     reset_i,
   // configuration
   input  wire ltc_pkg::ltc_timing_cfg_s cfg_i,
   // timing engine
   output logic                          timing_tick_o,
   output logic [15:0]                   timing_count_o,
   output logic                          third_led_on_o
);

   generate
      if (CONV_TICK_CYCLES < 1 || CONV_TICK_CYCLES > 65535) begin : g_bad
         $error("conversion tick period out of range");
      end
   endgenerate

   logic [15:0] conv_cnt_q;
   logic        conv_tick;
   logic [4:0]  ratio;
   logic [4:0]  presc_q;

   // reserved codes 1-3 fall back to ratio 1 so the engine never stalls
   always_comb begin
      case (cfg_i.timing_clock_div_sel)
         `LTC_DIV_CODE_BY2:  ratio = `LTC_RATIO_2;  // see RL3
         `LTC_DIV_CODE_BY4:  ratio = `LTC_RATIO_4;
         `LTC_DIV_CODE_BY8:  ratio = `LTC_RATIO_8;
         `LTC_DIV_CODE_BY16: ratio = `LTC_RATIO_16;
         default:            ratio = `LTC_RATIO_1;
      endcase
   end

   assign conv_tick = (conv_cnt_q == 16'(CONV_TICK_CYCLES - 1));

   // conversion clock rate derived from the core clock
   always_ff @(posedge core_clk_i) begin
      if (reset_i || conv_tick) begin
         conv_cnt_q <= '0;
      end else begin
         conv_cnt_q <= conv_cnt_q + 16'h0001;
      end
   end

   // timing tick is one conversion tick in every ratio
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         presc_q       <= '0;
         timing_tick_o <= 1'b0;
      end else begin
         timing_tick_o <= 1'b0;
         if (conv_tick) begin
            if (presc_q >= ratio - `LTC_RATIO_1) begin  // see RL4
               presc_q       <= '0;
               timing_tick_o <= 1'b1;
            end else begin
               presc_q <= presc_q + `LTC_RATIO_1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         timing_count_o <= '0;
      end else if (timing_tick_o) begin
         timing_count_o <= timing_count_o + 16'h0001;
      end
   end

   // both counts zero means the third LED is unused
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         third_led_on_o <= 1'b0;
      end else begin
         third_led_on_o <= ((cfg_i.third_led_start_count != '0) ||
                            (cfg_i.third_led_end_count != '0)) &&
                           (timing_count_o >= cfg_i.third_led_start_count) &&
                           (timing_count_o <= cfg_i.third_led_end_count);  // see RL9
      end
   end

endmodule // ltc_timing

// [ltc_core.sv]
`timescale 1ns/100ps
`include "ltc_regs.svh"

module ltc_core #(
   parameter logic [6:0] DEV_ADDR         = 7'h2a,  // arbitrary value
   parameter int         CONV_TICK_CYCLES = `LTC_CORE_CLK_KHZ / `LTC_CONV_CLK_KHZ
) (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     reset_i,
   // serial host port
   input  wire logic                     scl_i,
   input  wire logic                     sda_i,
   output logic                          sda_o,
   output logic                          sda_oe_o,
   // configuration outputs
   output ltc_pkg::ltc_offset_dac_s      offset_dac_o,
   output ltc_pkg::ltc_timing_cfg_s      timing_cfg_o,
   // timing engine
   output logic                          timing_tick_o,
   output logic [15:0]                   timing_count_o,
   output logic                          third_led_on_o
);

   generate
      if (DEV_ADDR == 7'h00) begin : g_bad_addr
         $error("device address must not be the general call address");
      end
   endgenerate

   ltc_pkg::ltc_port_state_e state_q;
   logic        scl_q;
   logic        sda_q;
   logic        start_det;
   logic        stop_det;
   logic        scl_rise;
   logic        scl_fall;
   logic [2:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  byte_in;
   logic [7:0]  rshift_q;
   logic [1:0]  byte_idx_q;
   logic [7:0]  reg_addr_q;
   logic [15:0] wbuf_q;
   logic        wr_stb_q;
   logic [23:0] wr_data_q;
   logic [23:0] rd_word;
   logic [7:0]  rd_byte;

   // pins are synchronous, so one stage of history gives the edges
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   assign start_det = scl_i && scl_q && sda_q && !sda_i;
   assign stop_det  = scl_i && scl_q && !sda_q && sda_i;
   assign scl_rise  = scl_i && !scl_q;
   assign scl_fall  = !scl_i && scl_q;
   assign byte_in   = {shift_q[6:0], sda_i};

   // read view; reserved bits read as zero
   always_comb begin
      if (reg_addr_q == `LTC_ADDR_LED3_START) begin
         rd_word = {8'h00, timing_cfg_o.third_led_start_count};  // see RL1
      end else if (reg_addr_q == `LTC_ADDR_LED3_END) begin
         rd_word = {8'h00, timing_cfg_o.third_led_end_count};  // see RL2
      end else if (reg_addr_q == `LTC_ADDR_CLK_DIV) begin
         rd_word = {21'h00_0000, timing_cfg_o.timing_clock_div_sel};  // see RL3
      end else if (reg_addr_q == `LTC_ADDR_OFFSET_DAC) begin
         rd_word = {4'h0, offset_dac_o};  // see RL8
      end else begin
         rd_word = `LTC_READ_ZERO;
      end
   end

   always_comb begin
      case (byte_idx_q)
         2'h0:    rd_byte = rd_word[23:16];
         2'h1:    rd_byte = rd_word[15:8];
         default: rd_byte = rd_word[7:0];
      endcase
   end

   // serial protocol: address byte, register byte, three data bytes msb first
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_q    <= ltc_pkg::ST_IDLE;
         bit_cnt_q  <= '0;
         shift_q    <= '0;
         rshift_q   <= '0;
         byte_idx_q <= '0;
         reg_addr_q <= '0;
         wbuf_q     <= '0;
         wr_stb_q   <= 1'b0;
         wr_data_q  <= '0;
      end else begin
         wr_stb_q <= 1'b0;
         if (start_det) begin
            state_q   <= ltc_pkg::ST_DEV_ADDR;
            bit_cnt_q <= '0;
         end else if (stop_det) begin
            state_q <= ltc_pkg::ST_IDLE;
         end else if (scl_rise) begin
            case (state_q)
               ltc_pkg::ST_DEV_ADDR: begin
                  shift_q   <= byte_in;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == `LTC_BITS_PER_BYTE) begin
                     state_q <= (shift_q[6:0] == DEV_ADDR) ? ltc_pkg::ST_ACK_ADDR
                                                           : ltc_pkg::ST_IDLE;
                  end
               end
               ltc_pkg::ST_ACK_ADDR: begin
                  bit_cnt_q <= '0;
                  if (shift_q[0]) begin
                     state_q    <= ltc_pkg::ST_RDATA;
                     rshift_q   <= rd_byte;
                     byte_idx_q <= 2'h1;
                  end else begin
                     state_q <= ltc_pkg::ST_REG_ADDR;
                  end
               end
               ltc_pkg::ST_REG_ADDR: begin
                  shift_q   <= byte_in;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == `LTC_BITS_PER_BYTE) begin
                     reg_addr_q <= byte_in;
                     byte_idx_q <= '0;
                     state_q    <= ltc_pkg::ST_ACK_REG;
                  end
               end
               ltc_pkg::ST_ACK_REG, ltc_pkg::ST_ACK_WDATA: begin
                  bit_cnt_q <= '0;
                  state_q   <= ltc_pkg::ST_WDATA;
               end
               ltc_pkg::ST_WDATA: begin
                  shift_q   <= byte_in;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == `LTC_BITS_PER_BYTE) begin
                     wbuf_q  <= {wbuf_q[7:0], byte_in};
                     state_q <= ltc_pkg::ST_ACK_WDATA;
                     if (byte_idx_q == `LTC_LAST_BYTE) begin
                        wr_stb_q   <= 1'b1;
                        wr_data_q  <= {wbuf_q, byte_in};
                        byte_idx_q <= '0;
                     end else begin
                        byte_idx_q <= byte_idx_q + 2'h1;
                     end
                  end
               end
               ltc_pkg::ST_RDATA: begin
                  rshift_q  <= {rshift_q[6:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == `LTC_BITS_PER_BYTE) begin
                     state_q <= ltc_pkg::ST_RACK;
                  end
               end
               ltc_pkg::ST_RACK: begin
                  bit_cnt_q <= '0;
                  if (sda_i) begin
                     state_q <= ltc_pkg::ST_IDLE;
                  end else begin
                     state_q    <= ltc_pkg::ST_RDATA;
                     rshift_q   <= rd_byte;
                     byte_idx_q <= (byte_idx_q == `LTC_LAST_BYTE) ? 2'h0
                                                                  : byte_idx_q + 2'h1;
                  end
               end
               default: begin
                  state_q <= ltc_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // open drain: enable pulls the line low, data only changes while scl is low
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sda_o    <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         if (start_det || stop_det) begin
            sda_oe_o <= 1'b0;
         end else if (scl_fall) begin
            case (state_q)
               ltc_pkg::ST_ACK_ADDR,
               ltc_pkg::ST_ACK_REG,
               ltc_pkg::ST_ACK_WDATA: sda_oe_o <= 1'b1;
               ltc_pkg::ST_RDATA:     sda_oe_o <= !rshift_q[7];
               default:               sda_oe_o <= 1'b0;
            endcase
         end
      end
   end

   // reserved upper bits of a write are dropped
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         timing_cfg_o <= '0;  // see RL7
         offset_dac_o <= '0;
      end else if (wr_stb_q) begin
         if (reg_addr_q == `LTC_ADDR_LED3_START) begin
            timing_cfg_o.third_led_start_count <= wr_data_q[`LTC_COUNT_MSB:0];  // see RL1, RL6
         end else if (reg_addr_q == `LTC_ADDR_LED3_END) begin
            timing_cfg_o.third_led_end_count <= wr_data_q[`LTC_COUNT_MSB:0];  // see RL2
         end else if (reg_addr_q == `LTC_ADDR_CLK_DIV) begin
            timing_cfg_o.timing_clock_div_sel <= wr_data_q[`LTC_DIV_MSB:0];  // see RL3
         end else if (reg_addr_q == `LTC_ADDR_OFFSET_DAC) begin
            offset_dac_o <= wr_data_q[`LTC_DAC_MSB:0];  // see RL8
         end
      end
   end

   // the caller must keep the repetition rate legal for the chosen divider (see RL5)
   ltc_timing #(
      .CONV_TICK_CYCLES (CONV_TICK_CYCLES)
   ) u_timing (
      .core_clk_i     (core_clk_i),
      .reset_i        (reset_i),
      .cfg_i          (timing_cfg_o),
      .timing_tick_o  (timing_tick_o),
      .timing_count_o (timing_count_o),
      .third_led_on_o (third_led_on_o)
   );

endmodule // ltc_core

// [ltc_core_assertions.sv]
`timescale 1ns/100ps
module ltc_core_assertions #(
   parameter int CONV_TICK_CYCLES = 31
) (
   // clock and reset
   input wire logic                     core_clk_i,
   input wire logic                     reset_i,
   // watched ports
   input wire logic                     scl_i,
   input wire logic                     sda_oe_o,
   input wire ltc_pkg::ltc_offset_dac_s offset_dac_o,
   input wire ltc_pkg::ltc_timing_cfg_s timing_cfg_o,
   input wire logic                     timing_tick_o,
   input wire logic [15:0]              timing_count_o,
   input wire logic                     third_led_on_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   wire [2:0]  sel = timing_cfg_o.timing_clock_div_sel;
   // codes 1-3 fall back to ratio 1, as the designer chose
   wire [4:0]  ratio = sel[2] ? 5'h02 << sel[1:0] : 5'h01;
   wire [15:0] st = timing_cfg_o.third_led_start_count;
   wire [15:0] en = timing_cfg_o.third_led_end_count;
   wire        in_win = st <= timing_count_o && timing_count_o <= en && (st | en) != 16'h0000;
   logic [9:0] gap_q;
   logic [2:0] sel_q;
   logic       seen_q;
   // a gap is judged only after a whole period under one divider code
   always_ff @(posedge core_clk_i) begin
      sel_q <= sel;
      gap_q <= (reset_i || timing_tick_o) ? 10'h001 : gap_q + 10'h001;
      seen_q <= !reset_i && sel_q == sel && (seen_q || timing_tick_o);
   end
   property p_reset_clear;
      disable iff (1'b0) reset_i |=> timing_cfg_o == '0 && offset_dac_o == '0 && !sda_oe_o;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
   property p_count_step;
      timing_tick_o |=> timing_count_o == $past(timing_count_o) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step after tick");
   property p_count_hold;
      !timing_tick_o && !$past(reset_i) |=> $stable(timing_count_o);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved without tick");
   property p_tick_single;
      timing_tick_o |=> !timing_tick_o;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");
   property p_tick_gap;
      timing_tick_o && seen_q && sel_q == sel |-> gap_q == 10'(CONV_TICK_CYCLES * ratio);
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick period wrong for divider");
   property p_led_window;
      1'b1 |=> third_led_on_o == $past(in_win);
   endproperty
   a_led_window: assert property (p_led_window) else $error("led level wrong for window");
   property p_cfg_write;
      !$past(reset_i) && $changed(timing_cfg_o) |-> $past(scl_i, 2);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("timing fields changed off a write");
   property p_dac_write;
      !$past(reset_i) && $changed(offset_dac_o) |-> $past(scl_i, 2);
   endproperty
   a_dac_write: assert property (p_dac_write) else $error("offset fields changed off a write");
   property p_sda_low;
      !$past(reset_i) && $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data line moved with clock high");
   c_led_on: cover property (in_win);
endmodule // ltc_core_assertions
bind ltc_core ltc_core_assertions #(.CONV_TICK_CYCLES(CONV_TICK_CYCLES)) chk_u (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
   .offset_dac_o(offset_dac_o), .timing_cfg_o(timing_cfg_o), .timing_tick_o(timing_tick_o),
   .timing_count_o(timing_count_o), .third_led_on_o(third_led_on_o));

// [ltc_host_model.sv]
`timescale 1ns/100ps
module ltc_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
) (
   // clock and wire
   input  wire logic core_clk_i,
   input  wire logic sda_i,
   // host drivers, high means released
   output logic      scl_o,
   output logic      sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic half();
      repeat (4) @(negedge core_clk_i);
   endtask
   // data moves one cycle after the clock falls, never beside it
   task automatic bit_io(input logic b, output logic r);
      @(negedge core_clk_i);
      sda_o = b;
      half();
      scl_o = 1'b1;
      half();
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic start();
      sda_o = 1'b0;
      half();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      @(negedge core_clk_i);
      sda_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_o = 1'b1;
      half();
   endtask
   task automatic xfer(input logic [7:0] b, input logic m, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(m, a);
   endtask
   task automatic wr(input logic [7:0] ra, input logic [23:0] d, output logic nak);
      logic [7:0] r;
      logic [4:0] a;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
      xfer(ra, 1'b1, r, a[1]);
      // reserved bits go out as given, so callers keep them zero
      for (int i = 0; i < 3; i++) xfer(d[23-8*i -: 8], 1'b1, r, a[2+i]);
      stop();
      nak = |a;
   endtask
   task automatic rd(input logic [7:0] ra, output logic [23:0] d, output logic nak);
      logic [7:0] r;
      logic [2:0] a;
      logic       x;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
      xfer(ra, 1'b1, r, a[1]);
      stop();
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, r, a[2]);
      for (int i = 0; i < 3; i++) xfer(8'hff, 1'(i == 2), d[23-8*i -: 8], x);
      stop();
      nak = |a;
   endtask
endmodule // ltc_host_model

// [tb_ltc_core.sv]
`timescale 1ns/100ps
module tb_ltc_core;
   localparam int CONV = 2;
   localparam logic [7:0]  RA [4] = '{8'h36, 8'h37, 8'h3a, 8'h38};
   localparam logic [23:0] RV [4] = '{24'h00_a5c3, 24'h00_ffff, 24'h0a_b6d9, 24'h00_1234};
   // codes 1-3 stay unused
   localparam logic [2:0]  DC [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
   localparam int          RT [5] = '{2, 4, 8, 16, 1};
   logic                     core_clk_i;
   logic                     reset_i;
   logic                     scl;
   logic                     host_sda;
   logic                     sda_out;
   logic                     sda_oe;
   wire                      sda_w = host_sda & ~(sda_oe & ~sda_out);
   ltc_pkg::ltc_offset_dac_s dac;
   ltc_pkg::ltc_timing_cfg_s cfg;
   logic                     tick;
   logic [15:0]              cnt;
   logic                     led;
   logic [15:0]              st;
   int                       gap;
   int                       error_cnt = 0;
   int                       compares = 0;
   ltc_core #(.CONV_TICK_CYCLES(CONV)) dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe), .offset_dac_o(dac),
      .timing_cfg_o(cfg), .timing_tick_o(tick), .timing_count_o(cnt), .third_led_on_o(led));
   ltc_host_model host_u (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ack(input logic nak);
      compares++;
      if (nak !== 1'b0) begin
         error_cnt++;
         $display("[FAIL] %0t byte not acknowledged", $time);
      end
   endtask
   task automatic wr_t(input logic [7:0] a, input logic [23:0] d);
      logic n;
      host_u.wr(a, d, n);
      chk_ack(n);
   endtask
   task automatic rd_t(input logic [7:0] a, input logic [23:0] e);
      logic [23:0] d;
      logic        n;
      host_u.rd(a, d, n);
      chk_ack(n);
      chk(56'(d), 56'(e));
   endtask
   task automatic wait_led(input logic v);
      for (int k = 0; k < 4000 && led !== v; k++) @(negedge core_clk_i);
   endtask
   task automatic meas(output int g);
      for (int k = 0; k < 100 && tick !== 1'b1; k++) @(negedge core_clk_i);
      g = 0;
      do begin
         @(negedge core_clk_i);
         g++;
      end while (tick !== 1'b1 && g < 100);
   endtask
   task automatic conclude();
      $display("error_cnt %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #600000;
      error_cnt++;
      conclude();
   end
   initial begin
      reset_i = 1'b1;
      repeat (10) @(negedge core_clk_i);
      reset_i = 1'b0;
      chk(56'({cfg, dac}), 56'h0);
      for (int i = 0; i < 4; i++) rd_t(RA[i], 24'h00_0000);
      // 38h is unmapped: acknowledged, dropped, reads zero
      for (int i = 0; i < 4; i++) begin
         wr_t(RA[i], RV[i]);
         rd_t(RA[i], i == 3 ? 24'h00_0000 : RV[i]);
      end
      chk(56'({cfg.third_led_start_count, cfg.third_led_end_count}), 56'ha5c3_ffff);
      chk(56'(dac), 56'h0a_b6d9);
      for (int i = 0; i < 5; i++) begin
         wr_t(8'h39, {21'h0, DC[i]});
         rd_t(8'h39, {21'h0, DC[i]});
         meas(gap);
         meas(gap);
         chk(56'(gap), 56'(CONV * RT[i]));
      end
      // window placed well ahead of the counter so both writes land first
      st = cnt + 16'h0400;
      wr_t(8'h36, {8'h00, st});
      wr_t(8'h37, {8'h00, st + 16'h0003});
      wait_led(1'b1);
      chk(56'(cnt), 56'(st));
      wait_led(1'b0);
      chk(56'(cnt), 56'(st + 16'h0004));
      wr_t(8'h36, 24'h00_0000);
      wr_t(8'h37, 24'h00_0000);
      repeat (8) @(negedge core_clk_i);
      chk(56'(led), 56'h0);
      // mid-run reset must clear the offset fields written above
      reset_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      reset_i = 1'b0;
      chk(56'({cfg, dac}), 56'h0);
      rd_t(8'h3a, 24'h00_0000);
      conclude();
   end
endmodule // tb_ltc_core
